// ---- rtl/pnc_pkg.sv ----
package pnc_pkg;

   localparam int CLK_HZ = 40_000_000;
   localparam int NMI_MS = 200;
   localparam int TICK_MS = 100;
   localparam int NMI_CYC = CLK_HZ / 1000 * NMI_MS;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;

   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_CMD = 8'h04;
   localparam logic [7:0] A_NSRC = 8'h08;
   localparam logic [7:0] A_STAT = 8'h0C;
   localparam logic [7:0] A_OFFT = 8'h10;
   localparam logic [7:0] A_PGTO = 8'h14;
   localparam logic [7:0] A_FDLY = 8'h18;
   localparam logic [7:0] A_RSTT = 8'h1C;

   localparam int C_CPUEN = 0;
   localparam int C_RESTART = 1;
   localparam int C_CPUNMI = 2;
   localparam int C_SMI = 3;
   localparam int C_NOTIFY = 4;
   localparam int C_ALERT = 5;
   localparam int C_RETAIN = 6;

   localparam int K_ON = 0;
   localparam int K_OFF = 1;
   localparam int K_CYC = 2;
   localparam int K_RST = 3;
   localparam int K_NMI = 4;
   localparam int K_NMIEN = 5;
   localparam int K_CLRF = 6;

   localparam logic [7:0] CTRL_RST = 8'h31;
   localparam logic [15:0] OFFT_RST = 16'h000A;
   localparam logic [15:0] PGTO_RST = 16'h000A;
   localparam logic [15:0] FDLY_RST = 16'h0000;
   localparam logic [15:0] RSTT_RST = 16'h0001;

   typedef enum logic [3:0] {
      ST_OFF, ST_UP_WAIT, ST_NOTIFY, ST_SENS, ST_FRB, ST_RUN, ST_RST_HOLD,
      ST_RST_ALERT, ST_DN_NOTIFY, ST_DN_PWR, ST_OFF_WAIT, ST_FAULT
   } pnc_state_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } pnc_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } pnc_apb_rsp_t;

   // Asynchronous pins from chassis and front panel
   typedef struct packed {
      logic pgood;
      logic pwr_btn;
      logic diag_btn;
      logic cpu_processor_internal_error;
      logic therm_trip;
      logic sleep_s5;
   } pnc_pins_t;

   // Same-clock pulses from watchdog, event filter and alert sender
   typedef struct packed {
      logic wdt_pre;
      logic wdt_pre_nmi;
      logic wdt_pre_smi;
      logic wdt_off;
      logic wdt_cyc;
      logic filt_nmi;
      logic filt_off;
      logic filt_cyc;
      logic filt_rst;
      logic alert_done;
   } pnc_evt_t;

   typedef struct packed {
      pnc_state_t state;
      pnc_pins_t sync1;
      pnc_pins_t sync2;
      pnc_pins_t prev;
      logic [31:0] tick_cnt;
      logic tick;
      logic [15:0] tmr;
      logic [31:0] ncnt;
      logic nmi;
      logic armed;
      logic [7:0] nsrc;
      logic smi;
      logic nlog;
      logic pon;
      logic rst;
      logic notify;
      logic sens;
      logic fault_resilient_boot;
      logic alert_req;
      logic alert_abort;
      logic alert_wdt;
      logic cyc;
      logic fault;
      logic loss;
      logic retain_pend;
      logic [2:0] fd_bits;
      logic [15:0] fd_tmr;
      logic fd_run;
      logic [7:0] ctrl;
      logic [15:0] offt;
      logic [15:0] pgto;
      logic [15:0] fdly;
      logic [15:0] rstt;
      pnc_apb_rsp_t apb;
   } pnc_regs_t;

endpackage

// ---- rtl/pnc_top.sv ----
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - NMI output is one 200 ms pulse
// - Five cause kinds may fire the NMI
// - Chassis-command NMI creates no log entry
// - One NMI, then silent until reset/off
// - NMI enable command re-arms the generator
// - Causes latched; reading source clears them
// - Set-source writes merge into latched causes
// - Watchdog pre-timeout raises SMI when enabled
// - Power-on request output, high means on
// - Power-good compared to command outside wait, fault and off
// - Power-good loss: reset, off, wait, retry
// - Power up holds reset until power-good
// - Then notify S0, init sensors, start boot
// - Power down: reset, notify, drop request
// - Button, watchdog, filter, command, retention, S5
// - Watchdog-off alert sent after power-down
// - Reset alert finishes before reset release
// - Reset, power-on or disable aborts alerts
// - Release reset after power-good and CPU enable
// - Filter power actions delayed in 100 ms units
module pnc_top #(
   parameter int P_TICK_CYCLES = pnc_pkg::TICK_CYC,
   parameter int P_NMI_CYCLES = pnc_pkg::NMI_CYC
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire pnc_pkg::pnc_apb_req_t i_apb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire pnc_pkg::pnc_pins_t i_pins,
   input wire pnc_pkg::pnc_evt_t i_evt,
   output logic o_pwr_on,
   output logic o_sys_rst,
   output logic o_nmi,
   output logic o_nmi_log,
   output logic o_smi,
   output logic o_notify_s0,
   output logic o_sensor_init,
   output logic o_frb_start,
   output logic o_alert_req,
   output logic o_alert_abort
);
   import pnc_pkg::*;

   pnc_regs_t r_reg;
   pnc_regs_t r_next;
   pnc_pins_t s;
   pnc_pins_t rise;
   pnc_pins_t fall;
   logic acc, done, wr, rd, pg_lost;
   logic go_on, go_off, go_cyc, go_rst;
   logic [7:0] cmd;
   logic [4:0] cause;
   logic [2:0] fexec;
   logic [31:0] rdv;

   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a[1:0] == 2'b00) && (a <= A_RSTT);
   endfunction

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      r_next = r_reg;
      r_next.sync1 = i_pins;
      r_next.sync2 = r_reg.sync1;
      r_next.prev = r_reg.sync2;
      s = r_reg.sync2;
      rise = s & ~r_reg.prev;
      fall = ~s & r_reg.prev;

      // Time base shared by every 100 ms count
      r_next.tick = 1'b0;
      r_next.tick_cnt = r_reg.tick_cnt + 32'h00000001;
      if (r_reg.tick_cnt >= 32'(P_TICK_CYCLES - 1)) begin
         r_next.tick_cnt = '0;
         r_next.tick = 1'b1;
      end

      // APB slave: one wait state, answer registered
      acc = i_apb.psel & i_apb.penable;
      done = acc & r_reg.apb.pready;
      wr = done & i_apb.pwrite & reg_hit(i_apb.paddr);
      rd = done & ~i_apb.pwrite & reg_hit(i_apb.paddr);
      case (i_apb.paddr)
         A_CTRL: rdv = {24'h000000, r_reg.ctrl};
         A_NSRC: rdv = {24'h000000, r_reg.nsrc};
         A_STAT: rdv = {20'h00000, r_reg.fault, r_reg.loss, r_reg.armed, s.pgood,
                        r_reg.rst, r_reg.pon, r_reg.alert_req, r_reg.nmi, r_reg.state};
         A_OFFT: rdv = {16'h0000, r_reg.offt};
         A_PGTO: rdv = {16'h0000, r_reg.pgto};
         A_FDLY: rdv = {16'h0000, r_reg.fdly};
         A_RSTT: rdv = {16'h0000, r_reg.rstt};
         default: rdv = 32'h00000000;
      endcase
      r_next.apb.pready = acc & ~r_reg.apb.pready;
      r_next.apb.pslverr = acc & ~r_reg.apb.pready & ~reg_hit(i_apb.paddr);
      if (acc && !r_reg.apb.pready) begin
         r_next.apb.prdata = i_apb.pwrite ? 32'h00000000 : rdv;
      end
      cmd = (wr && i_apb.paddr == A_CMD) ? i_apb.pwdata[7:0] : 8'h00;
      if (wr) begin
         case (i_apb.paddr)
            A_CTRL: r_next.ctrl = i_apb.pwdata[7:0];
            A_OFFT: r_next.offt = i_apb.pwdata[15:0];
            A_PGTO: r_next.pgto = i_apb.pwdata[15:0];
            A_FDLY: r_next.fdly = i_apb.pwdata[15:0];
            A_RSTT: r_next.rstt = i_apb.pwdata[15:0];
            default: r_next.ctrl = r_reg.ctrl;
         endcase
      end

      ////////////////////////////////////////////////////////////////
      // NMI causes, source record and single-shot pulse
      cause = {i_evt.wdt_pre & i_evt.wdt_pre_nmi,
               r_reg.ctrl[C_CPUNMI] & (rise.cpu_processor_internal_error | rise.therm_trip),
               i_evt.filt_nmi, rise.diag_btn, cmd[K_NMI]};
      // Set wins over the read clear
      r_next.nsrc = (rd && i_apb.paddr == A_NSRC) ? 8'h00 : r_reg.nsrc;
      r_next.nsrc = r_next.nsrc | {3'b000, cause};
      if (wr && i_apb.paddr == A_NSRC) begin
         r_next.nsrc = r_next.nsrc | i_apb.pwdata[7:0];
      end
      r_next.nlog = 1'b0;
      if (r_reg.nmi) begin
         r_next.ncnt = r_reg.ncnt - 32'h00000001;
         if (r_reg.ncnt == 32'h00000000) begin
            r_next.nmi = 1'b0;
         end
      end
      if (r_reg.armed && cause != 5'b00000) begin
         r_next.armed = 1'b0;
         if (!r_reg.nmi) begin
            r_next.nmi = 1'b1;
            r_next.ncnt = 32'(P_NMI_CYCLES - 1);
         end
         r_next.nlog = |cause[4:1];
      end
      if (cmd[K_NMIEN]) begin
         r_next.armed = 1'b1;
      end
      r_next.smi = i_evt.wdt_pre & i_evt.wdt_pre_smi & r_reg.ctrl[C_SMI];

      ////////////////////////////////////////////////////////////////
      // Event-filter power actions wait a programmed delay
      fexec = 3'b000;
      if (i_evt.filt_off || i_evt.filt_cyc || i_evt.filt_rst) begin
         r_next.fd_bits = r_reg.fd_bits | {i_evt.filt_off, i_evt.filt_cyc, i_evt.filt_rst};
         r_next.fd_tmr = r_reg.fdly;
         r_next.fd_run = 1'b1;
      end else if (r_reg.fd_run && r_reg.tick) begin
         if (r_reg.fd_tmr == 16'h0000) begin
            fexec = r_reg.fd_bits;
            r_next.fd_bits = 3'b000;
            r_next.fd_run = 1'b0;
         end else begin
            r_next.fd_tmr = r_reg.fd_tmr - 16'h0001;
         end
      end

      // Power-down beats cycle, cycle beats reset
      go_off = rise.pwr_btn | i_evt.wdt_off | cmd[K_OFF] | rise.sleep_s5
               | fexec[2];
      go_cyc = i_evt.wdt_cyc | cmd[K_CYC] | fexec[1];
      go_rst = cmd[K_RST] | (fexec[0] & ~fexec[1]);
      go_on = rise.pwr_btn | cmd[K_ON] | fall.sleep_s5
              | (r_reg.retain_pend & r_reg.ctrl[C_RETAIN]);

      // Alert handshake
      r_next.alert_abort = 1'b0;
      if (i_evt.alert_done) begin
         r_next.alert_req = 1'b0;
         r_next.alert_wdt = 1'b0;
      end
      if (i_evt.wdt_off || i_evt.wdt_cyc) begin
         r_next.alert_wdt = r_reg.ctrl[C_ALERT];
      end
      // Clear first so that a fault or loss raised below wins
      if (cmd[K_CLRF]) begin
         r_next.fault = 1'b0;
         r_next.loss = 1'b0;
      end

      r_next.notify = 1'b0;
      r_next.sens = 1'b0;
      r_next.fault_resilient_boot = 1'b0;

      ////////////////////////////////////////////////////////////////
      case (r_reg.state)
         ST_OFF: begin
            r_next.pon = 1'b0;
            if (r_reg.alert_wdt && r_reg.ctrl[C_ALERT] && !r_reg.alert_req) begin
               r_next.alert_req = 1'b1;
            end
            if (cmd[K_OFF]) begin
               r_next.retain_pend = 1'b0;
            end else if (go_on) begin
               r_next.pon = 1'b1;
               r_next.retain_pend = 1'b0;
               r_next.tmr = r_reg.pgto;
               r_next.state = ST_UP_WAIT;
            end
         end
         ST_UP_WAIT: begin
            if (s.pgood) begin
               r_next.notify = 1'b1;
               r_next.state = ST_NOTIFY;
            end else if (r_reg.tick) begin
               if (r_reg.tmr == 16'h0000) begin
                  r_next.pon = 1'b0;
                  r_next.fault = 1'b1;
                  r_next.state = ST_FAULT;
               end else begin
                  r_next.tmr = r_reg.tmr - 16'h0001;
               end
            end
         end
         ST_NOTIFY: begin
            r_next.sens = 1'b1;
            r_next.state = ST_SENS;
         end
         ST_SENS: begin
            r_next.state = ST_FRB;
         end
         ST_FRB: begin
            if (s.pgood && r_reg.ctrl[C_CPUEN]) begin
               r_next.rst = 1'b0;
               r_next.fault_resilient_boot = 1'b1;
               r_next.state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (go_off || go_cyc) begin
               r_next.rst = 1'b1;
               r_next.cyc = go_cyc & ~go_off;
               r_next.state = ST_DN_NOTIFY;
            end else if (go_rst) begin
               r_next.rst = 1'b1;
               r_next.tmr = r_reg.rstt;
               r_next.state = ST_RST_HOLD;
            end
         end
         ST_RST_HOLD: begin
            if (r_reg.tick) begin
               if (r_reg.tmr == 16'h0000) begin
                  r_next.alert_req = r_reg.ctrl[C_ALERT];
                  r_next.state = ST_RST_ALERT;
               end else begin
                  r_next.tmr = r_reg.tmr - 16'h0001;
               end
            end
         end
         ST_RST_ALERT: begin
            if (!r_reg.alert_req) begin
               r_next.state = ST_FRB;
            end
         end
         ST_DN_NOTIFY: begin
            r_next.notify = r_reg.ctrl[C_NOTIFY];
            r_next.state = ST_DN_PWR;
         end
         ST_DN_PWR: begin
            r_next.pon = 1'b0;
            r_next.tmr = r_reg.offt;
            r_next.state = r_reg.cyc ? ST_OFF_WAIT : ST_OFF;
         end
         ST_OFF_WAIT: begin
            if (r_reg.tick) begin
               if (r_reg.tmr == 16'h0000) begin
                  r_next.pon = 1'b1;
                  r_next.tmr = r_reg.pgto;
                  r_next.state = ST_UP_WAIT;
               end else begin
                  r_next.tmr = r_reg.tmr - 16'h0001;
               end
            end
         end
         ST_FAULT: begin
            r_next.pon = 1'b0;
            if (cmd[K_CLRF]) begin
               r_next.state = ST_OFF;
            end
         end
         default: r_next.state = ST_OFF;
      endcase

      // All states but the power-up wait, off wait, fault and off states compare power-good against the request
      pg_lost = ~s.pgood & r_reg.pon & (r_reg.state != ST_UP_WAIT)
                & (r_reg.state != ST_OFF_WAIT) & (r_reg.state != ST_FAULT)
                & (r_reg.state != ST_OFF);
      if (pg_lost) begin
         r_next.rst = 1'b1;
         r_next.pon = 1'b0;
         r_next.loss = 1'b1;
         r_next.cyc = 1'b0;
         r_next.tmr = r_reg.offt;
         r_next.state = r_reg.ctrl[C_RESTART] ? ST_OFF_WAIT : ST_OFF;
      end
      // Reset entry, power-on or alert disable ends an alert in flight
      if (r_next.alert_req && (!r_reg.ctrl[C_ALERT] || (r_next.rst && !r_reg.rst)
          || (r_next.pon && !r_reg.pon))) begin
         r_next.alert_req = 1'b0;
         r_next.alert_wdt = 1'b0;
         r_next.alert_abort = 1'b1;
      end
      // Host reset or power-down re-arms the NMI
      if (r_next.rst && !r_reg.rst) begin
         r_next.armed = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         r_reg <= '0;
         r_reg.state <= ST_OFF;
         r_reg.rst <= 1'b1;
         r_reg.armed <= 1'b1;
         r_reg.retain_pend <= 1'b1;
         r_reg.ctrl <= CTRL_RST;
         r_reg.offt <= OFFT_RST;
         r_reg.pgto <= PGTO_RST;
         r_reg.fdly <= FDLY_RST;
         r_reg.rstt <= RSTT_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   assign o_prdata = r_reg.apb.prdata;
   assign o_pready = r_reg.apb.pready;
   assign o_pslverr = r_reg.apb.pslverr;
   assign o_pwr_on = r_reg.pon;
   assign o_sys_rst = r_reg.rst;
   assign o_nmi = r_reg.nmi;
   assign o_nmi_log = r_reg.nlog;
   assign o_smi = r_reg.smi;
   assign o_notify_s0 = r_reg.notify;
   assign o_sensor_init = r_reg.sens;
   assign o_frb_start = r_reg.fault_resilient_boot;
   assign o_alert_req = r_reg.alert_req;
   assign o_alert_abort = r_reg.alert_abort;

   ////////////////////////////////////////////////////////////////////
   logic [31:0] hi_len;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hi_len <= '0;
      end else begin
         hi_len <= o_nmi ? hi_len + 32'h00000001 : 32'h00000000;
      end
   end

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   sequence s_up_steps;
      o_notify_s0 ##1 o_sensor_init;
   endsequence

   a_nmi_width: assert property ($fell(o_nmi) |-> hi_len == 32'(P_NMI_CYCLES))
      else $error("NMI pulse width wrong");
   a_nmi_single: assert property ($rose(o_nmi) |-> !r_reg.armed)
      else $error("NMI left armed after pulse");
   a_nmi_rearm: assert property (cmd[K_NMIEN] |=> r_reg.armed)
      else $error("NMI enable did not re-arm");
   a_src_clear: assert property ((rd && i_apb.paddr == A_NSRC && cause == 5'b00000
      && !(wr && i_apb.paddr == A_NSRC)) |=> r_reg.nsrc == 8'h00)
      else $error("NMI source not cleared by read");
   a_chas_nolog: assert property (o_nmi_log |-> $past(|cause[4:1]))
      else $error("Chassis NMI logged");
   a_smi_cause: assert property (o_smi |-> $past(i_evt.wdt_pre && r_reg.ctrl[C_SMI]))
      else $error("SMI without enabled pre-timeout");
   a_pg_loss: assert property ((r_reg.state == ST_RUN && !s.pgood)
      |=> o_sys_rst && !o_pwr_on)
      else $error("Power-good loss not handled");
   a_up_reset: assert property ((r_reg.state == ST_UP_WAIT) |-> o_sys_rst && o_pwr_on)
      else $error("Reset released without power-good");
   a_rst_release: assert property ($fell(o_sys_rst)
      |-> $past(s.pgood && r_reg.ctrl[C_CPUEN]) ##0 o_frb_start)
      else $error("Reset released too early");
   a_up_order: assert property ($rose(r_reg.state == ST_NOTIFY) |-> s_up_steps)
      else $error("Power-up steps out of order");
   a_dn_order: assert property ($fell(o_pwr_on) |-> o_sys_rst)
      else $error("Request dropped before reset");
   a_pg_fault: assert property ((r_reg.state == ST_FAULT) |-> !o_pwr_on && o_sys_rst)
      else $error("Fault state still powered");
   a_wdt_alert: assert property ((o_alert_req && r_reg.alert_wdt
      && r_reg.state == ST_OFF) |-> !o_pwr_on)
      else $error("Watchdog alert before power-down");

endmodule

`default_nettype wire

// ---- verification/platform_power_nmi_control_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module platform_power_nmi_control_tb;
   import pnc_pkg::*;
   localparam int TK = 10;
   localparam int NM = 20;
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   pnc_apb_req_t apb = '0;
   pnc_pins_t pins = '0;
   pnc_evt_t evt = '0;
   logic [31:0] prdata;
   logic pready, pslverr, pon, srst, nmi, nlog, smi, ntf, sens, fault_resilient_boot, pgood, areq, aab;
   logic fail = 1'b0;
   logic [7:0] dly = 8'h05;
   logic [31:0] seed = 32'h000142C4;
   logic [32:0] expq[$];
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int n, m;
   logic s, l, f1, f2;

   always #12.5 i_clk = ~i_clk;

   pnc_top #(.P_TICK_CYCLES(TK), .P_NMI_CYCLES(NM)) pnc_top_i (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_apb(apb), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_pins(pnc_pins_t'({pgood, pins[4:0]})),
      .i_evt(evt), .o_pwr_on(pon), .o_sys_rst(srst), .o_nmi(nmi), .o_nmi_log(nlog),
      .o_smi(smi), .o_notify_s0(ntf), .o_sensor_init(sens), .o_frb_start(fault_resilient_boot),
      .o_alert_req(areq), .o_alert_abort(aab));
   pnc_psu_model pnc_psu_model_i (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_pwr_on(pon),
      .i_fail(fail), .i_dly(dly), .o_pgood(pgood));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] r;
      r = v ^ (v << 13);
      r = r ^ (r >> 17);
      return r ^ (r << 5);
   endfunction

   task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wrap_up();
      if (err_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Reads queue {pslverr, prdata}; the monitor below compares them
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      @(posedge i_clk);
      apb <= '{1'b1, 1'b0, wr, a, d};
      if (!wr) expq.push_back(e);
      @(posedge i_clk);
      apb.penable <= 1'b1;
      @(posedge i_clk);
      while (pready !== 1'b1) @(posedge i_clk);
      apb.psel <= 1'b0;
      apb.penable <= 1'b0;
   endtask

   always @(posedge i_clk) begin
      if (pready === 1'b1 && apb.pwrite === 1'b0) begin
         if (expq.size() == 0) chk("apb spare read", 33'h0, 33'h1);
         else chk("apb read", {pslverr, prdata}, expq.pop_front());
      end
   end

   // Cause k: 0 command, 1 button, 2 filter, 3 cpu error, 4 wdt nmi, 5 wdt smi
   task automatic fire(input int k);
      pnc_evt_t e;
      e = '0;
      e.filt_nmi = (k == 2);
      e.wdt_pre = (k >= 4);
      e.wdt_pre_nmi = (k == 4);
      e.wdt_pre_smi = (k == 5);
      if (k == 0) bus(1'b1, A_CMD, 32'h00000010, '0);
      n = 0;
      s = 1'b0;
      l = 1'b0;
      for (int i = 0; i < 42; i++) begin
         @(posedge i_clk);
         n += (nmi === 1'b1);
         s |= (smi === 1'b1);
         l |= (nlog === 1'b1);
         if (i == 0) begin
            evt <= e;
            pins.diag_btn <= (k == 1);
            pins.cpu_processor_internal_error <= (k == 3);
         end
         if (i == 1) evt <= '0;
      end
      pins.diag_btn <= 1'b0;
      pins.cpu_processor_internal_error <= 1'b0;
   endtask

   task automatic pwr_up();
      bus(1'b1, A_CMD, 32'h00000001, '0);
      f1 = 1'b0;
      do begin
         @(posedge i_clk);
         if (sens === 1'b1) chk("notify first", f1, 1'b1);
         if (ntf === 1'b1) f1 = 1'b1;
         if (fault_resilient_boot !== 1'b1) chk("rst held", srst, 1'b1);
      end while (fault_resilient_boot !== 1'b1);
      chk("rst released", srst, 1'b0);
      chk("power request", pon, 1'b1);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         wrap_up();
      end
   end

   initial begin
      repeat (8) @(posedge i_clk);
      chk("rst in reset", srst, 1'b1);
      chk("pon in reset", pon, 1'b0);
      i_arst_n <= 1'b1;
      bus(1'b0, A_CTRL, '0, {25'h0, CTRL_RST});
      bus(1'b0, 8'h40, '0, 33'h100000000);
      seed = xs(seed);
      dly <= {3'h0, seed[4:0]};
      pwr_up();
      bus(1'b1, A_CTRL, 32'h00000035, '0);
      for (int k = 0; k < 5; k++) begin
         fire(k);
         chk("nmi width", n, NM);
         chk("nmi log", l, k != 0);
         bus(1'b1, A_CMD, 32'h00000020, '0);
      end
      bus(1'b0, A_NSRC, '0, 33'h00000001F);
      bus(1'b0, A_NSRC, '0, 33'h000000000);
      seed = xs(seed);
      bus(1'b1, A_NSRC, seed, '0);
      bus(1'b0, A_NSRC, '0, {25'h0, seed[7:0]});
      fire(0);
      fire(1);
      chk("nmi held off", n, 0);
      fire(5);
      chk("smi disabled", s, 1'b0);
      bus(1'b1, A_CTRL, 32'h0000003D, '0);
      fire(5);
      chk("smi enabled", s, 1'b1);
      // Button off from run: reset, then notify, then request drop
      pins.pwr_btn <= 1'b1;
      f1 = 1'b0;
      f2 = 1'b0;
      do begin
         @(posedge i_clk);
         if (pon === 1'b1) begin
            f1 |= (srst === 1'b1);
            f2 |= (ntf === 1'b1) && f1;
         end
      end while (pon === 1'b1);
      pins.pwr_btn <= 1'b0;
      chk("rst before off", f1, 1'b1);
      chk("notify on down", f2, 1'b1);
      // Slow supply this time, still inside the power-good timeout
      seed = xs(seed);
      dly <= {3'h1, seed[4:0]};
      pwr_up();
      fire(0);
      chk("nmi rearmed", n, NM);
      fail <= 1'b1;
      repeat (8) @(posedge i_clk);
      chk("loss rst", srst, 1'b1);
      chk("loss pon", pon, 1'b0);
      bus(1'b1, A_CMD, 32'h00000001, '0);
      repeat (130) @(posedge i_clk);
      chk("timeout pon", pon, 1'b0);
      chk("timeout rst", srst, 1'b1);
      bus(1'b1, A_CMD, 32'h00000001, '0);
      repeat (20) @(posedge i_clk);
      chk("fault holds off", pon, 1'b0);
      // Clear the fault, then a delayed filter reset with its alert
      bus(1'b1, A_CMD, 32'h00000040, '0);
      bus(1'b0, A_STAT, '0, 33'h000000280);
      fail <= 1'b0;
      pwr_up();
      bus(1'b1, A_FDLY, 32'h00000002, '0);
      evt.filt_rst <= 1'b1;
      m = 0;
      do begin
         @(posedge i_clk);
         evt.filt_rst <= 1'b0;
         m++;
      end while (srst !== 1'b1 && m < 100);
      chk("filter delay", (m > 2 * TK) && (m <= 3 * TK + 2), 1'b1);
      f1 = 1'b0;
      do begin
         @(posedge i_clk);
         f1 |= (srst !== 1'b1);
      end while (areq !== 1'b1);
      evt.alert_done <= 1'b1;
      do begin
         @(posedge i_clk);
         evt.alert_done <= 1'b0;
         f1 |= (srst !== 1'b1) && (fault_resilient_boot !== 1'b1);
      end while (fault_resilient_boot !== 1'b1);
      chk("rst until alert done", f1, 1'b0);
      chk("rst after alert", srst, 1'b0);
      // Watchdog power-down: alert only once power is off
      evt.wdt_off <= 1'b1;
      do begin
         @(posedge i_clk);
         evt.wdt_off <= 1'b0;
      end while (areq !== 1'b1);
      chk("alert after off", pon, 1'b0);
      // Power-on aborts the pending alert
      bus(1'b1, A_CMD, 32'h00000001, '0);
      f2 = 1'b0;
      repeat (2) begin
         @(posedge i_clk);
         f2 |= (aab === 1'b1);
      end
      chk("alert abort", f2, 1'b1);
      chk("alert dropped", areq, 1'b0);
      wrap_up();
   end
endmodule
`default_nettype wire

// ---- verification/pnc_psu_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module pnc_psu_model (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_pwr_on,
   input wire logic i_fail,
   input wire logic [7:0] i_dly,
   output logic o_pgood
);
   logic [7:0] cnt;
   // Good only after the ramp; drops at once when the request goes
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt <= 8'h00;
         o_pgood <= 1'b0;
      end else if (!i_pwr_on || i_fail) begin
         cnt <= 8'h00;
         o_pgood <= 1'b0;
      end else if (cnt >= i_dly) begin
         o_pgood <= 1'b1;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule
`default_nettype wire
